// ===== design/esc_powertrain_rx.sv
/*
 * Powertrain end: decodes received frames, substitutes defaults on loss of
 * communication, keeps the saved system type, picks idle thresholds and
 * runs the catalyst-monitor idle freeze.
 * Assumes the link and user inputs are on CLK_I; NV_SYS_TYPE_I is stable
 * across reset release.
 */
`timescale 1ns/100ps
`default_nettype none
module esc_powertrain_rx
    import esc_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DEF
) (
    // Clock, reset and enable.
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic CE_I,
    // Link.
    esc_link_if.rx LNK,
    // Engine state and calibration.
    input wire logic IN_GEAR_I,
    input wire logic [2:0][15:0] THR_IN_GEAR_I,
    input wire logic [2:0][15:0] THR_NO_GEAR_I,
    input wire logic [15:0] CUR_IDLE_I,
    input wire logic [15:0] MAX_IDLE_I,
    input wire logic CAT_MON_I,
    input wire logic TRIP_START_I,
    // Nonvolatile storage of the system type.
    input wire logic [SYS_W-1:0] NV_SYS_TYPE_I,
    output logic NV_WRITE_O,
    output logic [SYS_W-1:0] NV_SYS_TYPE_O,
    // Decoded signals.
    output logic COMM_LOST_O,
    output logic [INTEG_W-1:0] INTEGRITY_O,
    output logic SPEED_CTRL_EN_O,
    output logic SPEED_INC_O,
    output logic SPEED_DEC_O,
    output logic [SYS_W-1:0] SYS_TYPE_O,
    output logic [BOOST_W-1:0] BOOST_O,
    output logic [15:0] MIN_IDLE_O,
    output logic [TAP_W-1:0] TAP_EN_O,
    // Catalyst monitor idle freeze.
    output logic IDLE_FREEZE_O,
    output logic [15:0] FREEZE_IDLE_O
);
    localparam logic [31:0] MS_LAST = 32'(MS_CYCLES - 1);

    typedef struct packed {
        logic [31:0] pre;
        logic tick;
        logic nv_loaded;
        logic lost;
        logic [INTEG_W-1:0] integ;
        logic on_sw;
        logic inc_sw;
        logic dec_sw;
        logic spd_en;
        logic inc_out;
        logic dec_out;
        logic [SYS_W-1:0] sys_saved;
        logic [SYS_W-1:0] sys;
        logic nv_write;
        logic [BOOST_W-1:0] boost;
        logic [15:0] min_idle;
        logic [TAP_W-1:0] tap_en;
        logic cat_used;
        logic freeze;
        logic [15:0] freeze_rpm;
    } rx_s;

    localparam rx_s RX_RESET = '{
        pre: 32'h0000_0000, tick: 1'b0, nv_loaded: 1'b0, lost: 1'b1,
        integ: INTEG_INVALID, on_sw: 1'b0, inc_sw: 1'b0, dec_sw: 1'b0,
        spd_en: 1'b0, inc_out: 1'b0, dec_out: 1'b0, sys_saved: SYS_NONE, sys: SYS_NONE,
        nv_write: 1'b0, boost: BOOST_NONE, min_idle: 16'h0000, tap_en: TAP_NONE,
        cat_used: 1'b0, freeze: 1'b0, freeze_rpm: 16'h0000
    };

    function automatic logic [SYS_W-1:0] sys_decode(input logic [SYS_W-1:0] code);
        if (code > SYS_ENH_FAST_IDLE) begin
            sys_decode = SYS_NONE;
        end else begin
            sys_decode = code;
        end
    endfunction : sys_decode

    rx_s q;
    rx_s d;
    logic loss_done;
    logic cat_done;
    logic [1:0] lvl;

    esc_ms_timer u_loss (
        .clk_i(CLK_I),
        .reset_n_i(RESET_N_I),
        .ce_i(CE_I),
        .tick_i(q.tick),
        .run_i(!(LNK.sw_stb || LNK.cfg_stb)),
        .limit_i(LOSS_MS),
        .done_o(loss_done)
    );

    esc_ms_timer u_cat (
        .clk_i(CLK_I),
        .reset_n_i(RESET_N_I),
        .ce_i(CE_I),
        .tick_i(q.tick),
        .run_i(q.freeze),
        .limit_i(CAT_MON_MS),
        .done_o(cat_done)
    );

    assign lvl = q.boost - 2'h1;

    always_comb begin
        d = q;
        d.tick = (q.pre == MS_LAST);
        d.pre = d.tick ? 32'h0000_0000 : q.pre + 32'h0000_0001;
        d.nv_write = 1'b0;
        d.lost = loss_done;
        if (!q.nv_loaded) begin
            d.nv_loaded = 1'b1;
            d.sys_saved = NV_SYS_TYPE_I;
        end
        if (LNK.sw_stb) begin
            d.integ = LNK.integ;
            d.on_sw = LNK.on_sw;
            d.inc_sw = LNK.inc_sw;
            d.dec_sw = LNK.dec_sw;
        end
        if (LNK.cfg_stb) begin
            // Boost arrives from one arbitrated source only.
            d.boost = LNK.boost;
            d.tap_en = LNK.tap_en;
            if (q.nv_loaded && LNK.sys_type != q.sys_saved) begin
                d.sys_saved = LNK.sys_type;
                d.nv_write = 1'b1;
            end
        end
        // The frame that ends a silence is kept rather than overwritten.
        if (loss_done && !LNK.sw_stb && !LNK.cfg_stb) begin
            d.integ = INTEG_INVALID;
            d.on_sw = 1'b0;
            d.inc_sw = 1'b0;
            d.dec_sw = 1'b0;
            d.boost = BOOST_NONE;
            d.tap_en = TAP_NONE;
        end
        // The saved type stands in while the link is silent.
        d.sys = sys_decode(q.sys_saved);
        d.spd_en = (q.integ != INTEG_FAILURE) && q.on_sw && (q.sys != SYS_NONE);
        d.inc_out = d.inc_sw && (d.integ != INTEG_FAILURE);
        d.dec_out = d.dec_sw && (d.integ != INTEG_FAILURE);
        if (q.boost == BOOST_NONE) begin
            d.min_idle = 16'h0000;
        end else if (IN_GEAR_I) begin
            d.min_idle = THR_IN_GEAR_I[lvl];
        end else begin
            d.min_idle = THR_NO_GEAR_I[lvl];
        end
        if (TRIP_START_I) begin
            d.cat_used = 1'b0;
            d.freeze = 1'b0;
        end else if (!q.freeze && CAT_MON_I && !q.cat_used) begin
            d.freeze = 1'b1;
            d.cat_used = 1'b1;
            d.freeze_rpm = (CUR_IDLE_I < MAX_IDLE_I) ? CUR_IDLE_I : MAX_IDLE_I;
        end else if (q.freeze && (!CAT_MON_I || cat_done)) begin
            d.freeze = 1'b0;
        end
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            q <= RX_RESET;
        end else if (CE_I) begin
            q <= d;
        end
    end

    assign NV_WRITE_O = q.nv_write;
    assign NV_SYS_TYPE_O = q.sys_saved;
    assign COMM_LOST_O = q.lost;
    assign INTEGRITY_O = q.integ;
    assign SPEED_CTRL_EN_O = q.spd_en;
    assign SPEED_INC_O = q.inc_out;
    assign SPEED_DEC_O = q.dec_out;
    assign SYS_TYPE_O = q.sys;
    assign BOOST_O = q.boost;
    assign MIN_IDLE_O = q.min_idle;
    assign TAP_EN_O = q.tap_en;
    assign IDLE_FREEZE_O = q.freeze;
    assign FREEZE_IDLE_O = q.freeze_rpm;
endmodule : esc_powertrain_rx
`default_nettype wire

// ===== design/esc_pkg.sv
/*
 * Shared constants, codes and types for the engine speed command signal codec.
 * Assumes a single 250 MHz system clock shared by both ends of the link.
 */
package esc_pkg;

    localparam int CLK_NS = 4;
    localparam int MS_NS = 1_000_000;
    localparam int MS_CYCLES_DEF = MS_NS / CLK_NS;
    localparam logic [15:0] FRAME_MS = 16'h0028;
    localparam logic [15:0] LOSS_MS = 16'h0078;
    localparam int CAT_MON_S = 60;
    localparam logic [15:0] CAT_MON_MS = 16'(CAT_MON_S * 1000);

    localparam int INTEG_W = 2;
    localparam int SYS_W = 3;
    localparam int BOOST_W = 2;
    localparam int TAP_W = 2;
    localparam int FAULT_W = 2;

    localparam logic [INTEG_W-1:0] INTEG_VALID = 2'h0;
    localparam logic [INTEG_W-1:0] INTEG_INVALID = 2'h1;
    localparam logic [INTEG_W-1:0] INTEG_FAILURE = 2'h2;

    localparam logic [SYS_W-1:0] SYS_NONE = 3'h0;
    localparam logic [SYS_W-1:0] SYS_STAT_DRIVE = 3'h1;
    localparam logic [SYS_W-1:0] SYS_STAT_VAR_DRIVE = 3'h2;
    localparam logic [SYS_W-1:0] SYS_MOBILE_VAR_DRIVE = 3'h3;
    localparam logic [SYS_W-1:0] SYS_FAST_IDLE = 3'h4;
    localparam logic [SYS_W-1:0] SYS_ENH_FAST_IDLE = 3'h5;

    localparam logic [BOOST_W-1:0] BOOST_NONE = 2'h0;

    localparam logic [TAP_W-1:0] TAP_NONE = 2'h0;
    localparam logic [TAP_W-1:0] TAP_DRIVER_SHIFT = 2'h1;
    localparam logic [TAP_W-1:0] TAP_RANGE_SELECT = 2'h2;
    localparam logic [TAP_W-1:0] TAP_ILLEGAL = 2'h3;

    localparam logic [FAULT_W-1:0] FAULT_NONE = 2'h0;
    localparam logic [FAULT_W-1:0] FAULT_INVALID_COMBO = 2'h1;
    localparam logic [FAULT_W-1:0] FAULT_STUCK = 2'h2;

    typedef enum logic [2:0] {
        ST_VALID = 3'b001,
        ST_INVALID = 3'b010,
        ST_FAIL = 3'b100
    } integ_st_e;

endpackage : esc_pkg

// ===== design/esc_link_if.sv
/*
 * Serial-network frame carrier between the platform transmitter and the
 * powertrain receiver. Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface esc_link_if;
    import esc_pkg::*;
    logic sw_stb;
    logic [INTEG_W-1:0] integ;
    logic on_sw;
    logic inc_sw;
    logic dec_sw;
    logic cfg_stb;
    logic [SYS_W-1:0] sys_type;
    logic [BOOST_W-1:0] boost;
    logic [TAP_W-1:0] tap_en;

    modport tx (output sw_stb, integ, on_sw, inc_sw, dec_sw, cfg_stb, sys_type, boost, tap_en);
    modport rx (input sw_stb, integ, on_sw, inc_sw, dec_sw, cfg_stb, sys_type, boost, tap_en);
endinterface : esc_link_if
`default_nettype wire

// ===== design/esc_ms_timer.sv
/*
 * Millisecond interval timer: counts ticks while run is high.
 * Assumes a one-cycle tick per millisecond from the instantiating end.
 */
`timescale 1ns/100ps
`default_nettype none
module esc_ms_timer (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic tick_i,
    input wire logic run_i,
    input wire logic [15:0] limit_i,
    output logic done_o
);
    typedef struct packed {
        logic [15:0] cnt;
        logic done;
    } tmr_s;

    tmr_s q;
    tmr_s d;

    always_comb begin
        d = q;
        if (!run_i) begin
            d.cnt = 16'h0000;
        end else if (tick_i && q.cnt != 16'hFFFF) begin
            d.cnt = q.cnt + 16'h0001;
        end
        d.done = run_i && (d.cnt >= limit_i);
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            q <= '0;
        end else if (ce_i) begin
            q <= d;
        end
    end

    assign done_o = q.done;
endmodule : esc_ms_timer
`default_nettype wire

// ===== design/esc_platform_tx.sv
/*
 * Platform end: reads the speed command switches, qualifies faults, keeps
 * the integrity state and sends switch and configuration frames.
 * Assumes switch pins are asynchronous and configuration inputs are on CLK_I.
 */
`timescale 1ns/100ps
`default_nettype none
module esc_platform_tx
    import esc_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DEF
) (
    // Clock, reset and enable.
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic CE_I,
    // Link.
    esc_link_if.tx LNK,
    // Switch pins.
    input wire logic FITTED_I,
    input wire logic SW_ON_I,
    input wire logic SW_INC_I,
    input wire logic SW_DEC_I,
    input wire logic SW_OPEN_I,
    // Configuration.
    input wire logic [15:0] QUAL_MS_I,
    input wire logic [15:0] STUCK_MS_I,
    input wire logic [SYS_W-1:0] SYS_TYPE_I,
    input wire logic [BOOST_W-1:0] BOOST_I,
    input wire logic [TAP_W-1:0] TAP_EN_I,
    // Status.
    output logic [INTEG_W-1:0] INTEGRITY_O,
    output logic [FAULT_W-1:0] FAULT_CODE_O,
    output logic FAULT_STORE_O
);
    localparam logic [31:0] MS_LAST = 32'(MS_CYCLES - 1);

    typedef struct packed {
        logic [4:0] meta;
        logic [4:0] pins;
        logic [31:0] pre;
        logic tick;
        logic [15:0] frame_ms;
        integ_st_e st;
        logic [INTEG_W-1:0] integ;
        logic [FAULT_W-1:0] fault_code;
        logic fault_store;
        logic sw_stb;
        logic [INTEG_W-1:0] l_integ;
        logic on_sw;
        logic inc_sw;
        logic dec_sw;
        logic cfg_stb;
        logic [SYS_W-1:0] sys_type;
        logic [BOOST_W-1:0] boost;
        logic [TAP_W-1:0] tap_en;
    } tx_s;

    localparam tx_s TX_RESET = '{
        meta: 5'h00, pins: 5'h00, pre: 32'h0000_0000, tick: 1'b0,
        frame_ms: 16'h0000, st: ST_INVALID, integ: INTEG_INVALID,
        fault_code: FAULT_NONE, fault_store: 1'b0, sw_stb: 1'b0,
        l_integ: INTEG_INVALID, on_sw: 1'b0, inc_sw: 1'b0, dec_sw: 1'b0,
        cfg_stb: 1'b0, sys_type: SYS_NONE, boost: BOOST_NONE, tap_en: TAP_NONE
    };

    function automatic logic [INTEG_W-1:0] integ_code(input integ_st_e st);
        case (st)
            ST_VALID: integ_code = INTEG_VALID;
            ST_FAIL: integ_code = INTEG_FAILURE;
            default: integ_code = INTEG_INVALID;
        endcase
    endfunction : integ_code

    tx_s q;
    tx_s d;
    logic fitted;
    logic sw_on;
    logic sw_inc;
    logic sw_dec;
    logic sw_open;
    logic bad_now;
    logic qual_done;
    logic stuck_done;

    assign {fitted, sw_on, sw_inc, sw_dec, sw_open} = q.pins;
    // An undeterminate reading is both directions at once or an open switch.
    assign bad_now = (sw_inc && sw_dec) || sw_open;

    esc_ms_timer u_qual (
        .clk_i(CLK_I),
        .reset_n_i(RESET_N_I),
        .ce_i(CE_I),
        .tick_i(q.tick),
        .run_i(bad_now),
        .limit_i(QUAL_MS_I),
        .done_o(qual_done)
    );

    esc_ms_timer u_stuck (
        .clk_i(CLK_I),
        .reset_n_i(RESET_N_I),
        .ce_i(CE_I),
        .tick_i(q.tick),
        .run_i(sw_on || sw_inc || sw_dec),
        .limit_i(STUCK_MS_I),
        .done_o(stuck_done)
    );

    always_comb begin
        d = q;
        d.meta = {FITTED_I, SW_ON_I, SW_INC_I, SW_DEC_I, SW_OPEN_I};
        d.pins = q.meta;
        d.tick = (q.pre == MS_LAST);
        d.pre = d.tick ? 32'h0000_0000 : q.pre + 32'h0000_0001;
        d.fault_store = 1'b0;
        d.sw_stb = 1'b0;
        d.cfg_stb = 1'b0;
        case (q.st)
            ST_VALID: begin
                if (stuck_done) begin
                    d.st = ST_FAIL;
                    d.fault_code = FAULT_STUCK;
                    d.fault_store = 1'b1;
                end else if (qual_done) begin
                    d.st = ST_INVALID;
                    d.fault_code = FAULT_INVALID_COMBO;
                    d.fault_store = 1'b1;
                end
            end
            ST_INVALID: begin
                if (stuck_done) begin
                    d.st = ST_FAIL;
                    d.fault_code = FAULT_STUCK;
                    d.fault_store = 1'b1;
                end else if (!bad_now && !qual_done) begin
                    d.st = ST_VALID;
                end
            end
            ST_FAIL: begin
                d.st = ST_FAIL;
            end
            default: begin
                d.st = ST_INVALID;
            end
        endcase
        d.integ = integ_code(d.st);
        // A frame every 40 ms keeps every field inside its delay budget.
        if (q.tick) begin
            if (q.frame_ms >= FRAME_MS - 16'h0001) begin
                d.frame_ms = 16'h0000;
                d.cfg_stb = 1'b1;
                d.sw_stb = fitted;
                // Switch fields move only together with their own strobe.
                if (fitted) begin
                    d.l_integ = q.integ;
                    d.on_sw = sw_on && (q.st == ST_VALID);
                    d.inc_sw = sw_inc;
                    d.dec_sw = sw_dec;
                end
                d.sys_type = SYS_TYPE_I;
                d.boost = BOOST_I;
                d.tap_en = TAP_EN_I;
            end else begin
                d.frame_ms = q.frame_ms + 16'h0001;
            end
        end
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            q <= TX_RESET;
        end else if (CE_I) begin
            q <= d;
        end
    end

    assign LNK.sw_stb = q.sw_stb;
    assign LNK.integ = q.l_integ;
    assign LNK.on_sw = q.on_sw;
    assign LNK.inc_sw = q.inc_sw;
    assign LNK.dec_sw = q.dec_sw;
    assign LNK.cfg_stb = q.cfg_stb;
    assign LNK.sys_type = q.sys_type;
    assign LNK.boost = q.boost;
    assign LNK.tap_en = q.tap_en;
    assign INTEGRITY_O = q.integ;
    assign FAULT_CODE_O = q.fault_code;
    assign FAULT_STORE_O = q.fault_store;
endmodule : esc_platform_tx
`default_nettype wire

// ===== sim/esc_link_sva.sv
/*
 * Assertions on the frame carrier between the platform and powertrain ends.
 * Assumes instantiation beside the link with the transmitter's clock and reset.
 */
`timescale 1ns/100ps
`default_nettype none
module esc_link_sva
    import esc_pkg::*;
(
    // Clock and reset.
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    // Link signals.
    input wire logic sw_stb,
    input wire logic [INTEG_W-1:0] integ,
    input wire logic on_sw,
    input wire logic inc_sw,
    input wire logic dec_sw,
    input wire logic cfg_stb,
    input wire logic [SYS_W-1:0] sys_type,
    input wire logic [BOOST_W-1:0] boost,
    input wire logic [TAP_W-1:0] tap_en
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);

    sequence s_cfg_gap;
        !cfg_stb [*8];
    endsequence
    sequence s_sw_quiet;
        $stable(integ) && $stable({on_sw, inc_sw, dec_sw});
    endsequence

    a_onsw_when_invalid: assert property (integ == INTEG_INVALID |-> !on_sw)
        else $error("on flag sent true with invalid integrity");
    a_onsw_when_failed: assert property (integ == INTEG_FAILURE |-> !on_sw)
        else $error("on flag sent true with failure integrity");
    a_integ_code: assert property (integ != 2'h3)
        else $error("undefined integrity code sent");
    a_failure_latch: assert property (integ == INTEG_FAILURE |=> integ == INTEG_FAILURE)
        else $error("failure integrity left before reset");
    a_sw_in_cfg: assert property (sw_stb |-> cfg_stb)
        else $error("switch frame sent apart from the frame slot");
    a_cfg_spacing: assert property (cfg_stb |=> s_cfg_gap)
        else $error("frames sent too close together");
    a_sw_fields_hold: assert property (!sw_stb |-> s_sw_quiet)
        else $error("switch frame fields changed between frames");
    a_cfg_fields_hold: assert property (!cfg_stb |-> $stable({sys_type, boost, tap_en}))
        else $error("configuration fields changed between frames");
endmodule : esc_link_sva
`default_nettype wire

// ===== sim/engine_speed_cmd_signal_codec_tb.sv
/*
 * Self-checking bench joining the platform and powertrain ends over the link.
 * Assumes MS_CYCLES of 4, so one frame is 160 cycles.
 */
`timescale 1ns/100ps
`default_nettype none
module engine_speed_cmd_signal_codec_tb;
    import esc_pkg::*;
    typedef struct packed {
        logic [1:0] integ;
        logic en;
        logic [2:0] sys;
        logic [1:0] boost;
        logic [1:0] tap;
        logic [15:0] idle;
    } note_s;
    logic clk = 1'b0, rst_n = 1'b0, tx_rst_n = 1'b0;
    logic fitted = 1'b1, sw_on = 1'b1, sw_inc = 1'b0, sw_dec = 1'b0, sw_open = 1'b0;
    logic [15:0] qual_ms = 16'h0002, stuck_ms = 16'h0FFF, cur_idle = 16'h0000, max_idle = 16'h0000;
    logic [2:0] sys = 3'h0;
    logic [1:0] boost = 2'h0, tap = 2'h0, tx_integ, tx_fault, rx_integ, rx_boost, rx_tap;
    logic in_gear = 1'b0, cat_mon = 1'b0, trip = 1'b0;
    logic [2:0][15:0] thr_in = {16'h0C00, 16'h0B00, 16'h0A00};
    logic [2:0][15:0] thr_no = {16'h0900, 16'h0800, 16'h0700};
    logic rx_lost, rx_en, rx_inc, rx_dec, frz, fstore, nv_wr;
    logic [2:0] rx_sys, nv_sys;
    logic [15:0] rx_idle, frz_idle;
    int miscompares = 0, cmp_count = 0, ns = 0, nc = 0, n_store = 0, n_nvw = 0;
    note_s notes[$];

    always #2 clk = ~clk;

    // Counts the one-cycle fault-store and nonvolatile-write pulses.
    always @(posedge clk) begin
        if (fstore === 1'b1) begin
            n_store++;
        end
        if (nv_wr === 1'b1) begin
            n_nvw++;
        end
    end

    esc_link_if lnk();
    esc_platform_tx #(.MS_CYCLES(4)) esc_platform_tx_i (.CLK_I(clk), .RESET_N_I(tx_rst_n),
        .CE_I(1'b1), .LNK(lnk.tx), .FITTED_I(fitted), .SW_ON_I(sw_on), .SW_INC_I(sw_inc),
        .SW_DEC_I(sw_dec), .SW_OPEN_I(sw_open), .QUAL_MS_I(qual_ms), .STUCK_MS_I(stuck_ms),
        .SYS_TYPE_I(sys), .BOOST_I(boost), .TAP_EN_I(tap), .INTEGRITY_O(tx_integ),
        .FAULT_CODE_O(tx_fault), .FAULT_STORE_O(fstore));
    esc_powertrain_rx #(.MS_CYCLES(4)) esc_powertrain_rx_i (.CLK_I(clk), .RESET_N_I(rst_n),
        .CE_I(1'b1), .LNK(lnk.rx), .IN_GEAR_I(in_gear), .THR_IN_GEAR_I(thr_in),
        .THR_NO_GEAR_I(thr_no), .CUR_IDLE_I(cur_idle), .MAX_IDLE_I(max_idle),
        .CAT_MON_I(cat_mon), .TRIP_START_I(trip), .NV_SYS_TYPE_I(3'h3), .NV_WRITE_O(nv_wr),
        .NV_SYS_TYPE_O(nv_sys), .COMM_LOST_O(rx_lost), .INTEGRITY_O(rx_integ),
        .SPEED_CTRL_EN_O(rx_en), .SPEED_INC_O(rx_inc), .SPEED_DEC_O(rx_dec), .SYS_TYPE_O(rx_sys),
        .BOOST_O(rx_boost), .MIN_IDLE_O(rx_idle), .TAP_EN_O(rx_tap), .IDLE_FREEZE_O(frz),
        .FREEZE_IDLE_O(frz_idle));
    esc_link_sva esc_link_sva_i (.CLK_I(clk), .RESET_N_I(tx_rst_n), .sw_stb(lnk.sw_stb),
        .integ(lnk.integ), .on_sw(lnk.on_sw), .inc_sw(lnk.inc_sw), .dec_sw(lnk.dec_sw),
        .cfg_stb(lnk.cfg_stb), .sys_type(lnk.sys_type), .boost(lnk.boost), .tap_en(lnk.tap_en));

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic wait_frame;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!lnk.cfg_stb && n < 400);
        if (!lnk.cfg_stb) begin
            chk("frame strobe", 16'h0001, 16'h0000);
            tally_and_finish();
        end
    endtask : wait_frame

    // The note is queued one edge after a frame, so it belongs to the next frame.
    task automatic send(input logic [2:0] s, input logic [1:0] b, input logic [1:0] t,
                        input logic g, input logic [1:0] ei);
        note_s n;
        @(posedge clk);
        sys <= s;
        boost <= b;
        tap <= t;
        in_gear <= g;
        wait_frame();
        @(posedge clk);
        n.integ = ei;
        n.sys = (s > 3'h5) ? SYS_NONE : s;
        n.en = (ei == INTEG_VALID) && (n.sys != SYS_NONE);
        n.boost = b;
        n.tap = t;
        n.idle = (b == BOOST_NONE) ? 16'h0000 : (g ? thr_in[b-2'h1] : thr_no[b-2'h1]);
        notes.push_back(n);
        wait_frame();
        repeat (4) @(posedge clk);
    endtask : send

    always @(posedge clk) begin
        note_s n;
        if (lnk.cfg_stb && notes.size() > 0) begin
            n = notes.pop_front();
            repeat (2) @(posedge clk);
            #1;
            chk("tx integrity", 16'(n.integ), 16'(tx_integ));
            chk("rx integrity", 16'(n.integ), 16'(rx_integ));
            chk("speed control", 16'(n.en), 16'(rx_en));
            chk("system type", 16'(n.sys), 16'(rx_sys));
            chk("boost", 16'(n.boost), 16'(rx_boost));
            chk("tap enable", 16'(n.tap), 16'(rx_tap));
            chk("min idle", n.idle, rx_idle);
        end
    end

    initial begin
        void'($urandom(32'h4E76693A));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        tx_rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        // The loss timer has not run out yet, so the lost flag is low.
        chk("lost", 16'h0000, 16'(rx_lost));
        chk("rx integrity", 16'(INTEG_INVALID), 16'(rx_integ));
        chk("boost", 16'(BOOST_NONE), 16'(rx_boost));
        chk("saved type", 16'h0003, 16'(rx_sys));
        $display("test power-up done");
        for (int i = 0; i < 8; i++) begin
            send(3'(i), 2'($urandom), 2'(i), 1'($urandom), INTEG_VALID);
        end
        $display("test codes done");
        sw_inc <= 1'b1;
        sw_dec <= 1'b1;
        send(3'h4, 2'h1, 2'h0, 1'b1, INTEG_INVALID);
        chk("fault code", 16'(FAULT_INVALID_COMBO), 16'(tx_fault));
        chk("decrease", 16'h0001, 16'(rx_dec));
        sw_inc <= 1'b0;
        sw_dec <= 1'b0;
        send(3'h4, 2'h2, 2'h1, 1'b0, INTEG_VALID);
        $display("test invalid done");
        stuck_ms <= 16'h0003;
        sw_inc <= 1'b1;
        send(3'h1, 2'h3, 2'h2, 1'b1, INTEG_FAILURE);
        chk("increase", 16'h0000, 16'(rx_inc));
        chk("fault code", 16'(FAULT_STUCK), 16'(tx_fault));
        $display("test stuck done");
        @(posedge clk);
        fitted <= 1'b0;
        repeat (10) @(posedge clk);
        repeat (400) begin
            @(posedge clk);
            ns += int'(lnk.sw_stb);
            nc += int'(lnk.cfg_stb);
        end
        chk("switch frames", 16'h0000, 16'(ns));
        chk("config frames", 16'h0001, 16'(nc != 0));
        fitted <= 1'b1;
        $display("test absent done");
        stuck_ms <= 16'h0FFF;
        sw_inc <= 1'b0;
        tx_rst_n <= 1'b0;
        repeat (600) @(posedge clk);
        #1;
        chk("lost", 16'h0001, 16'(rx_lost));
        chk("rx integrity", 16'(INTEG_INVALID), 16'(rx_integ));
        chk("boost", 16'(BOOST_NONE), 16'(rx_boost));
        chk("saved type", 16'h0001, 16'(rx_sys));
        chk("nv saved", 16'h0001, 16'(nv_sys));
        @(posedge clk);
        tx_rst_n <= 1'b1;
        send(3'h5, 2'h3, 2'h3, 1'b0, INTEG_VALID);
        $display("test loss done");
        @(posedge clk);
        cur_idle <= 16'($urandom);
        max_idle <= 16'($urandom);
        cat_mon <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("freeze", 16'h0001, 16'(frz));
        chk("freeze rpm", (cur_idle < max_idle) ? cur_idle : max_idle, frz_idle);
        @(posedge clk);
        cat_mon <= 1'b0;
        repeat (3) @(posedge clk);
        cat_mon <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("second freeze", 16'h0000, 16'(frz));
        @(posedge clk);
        trip <= 1'b1;
        @(posedge clk);
        trip <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("new trip freeze", 16'h0001, 16'(frz));
        chk("fault stores", 16'h0002, 16'(n_store));
        chk("nv writes", 16'h000B, 16'(n_nvw));
        $display("test catalyst done");
        tally_and_finish();
    end
endmodule : engine_speed_cmd_signal_codec_tb
`default_nettype wire
